// >>> include/agdr_pkg.sv
// package: register map, field layout, reset values and debounce timing for the record-path gain register bank
package agdr_pkg;
    // register offsets
    localparam logic [7:0] OFS_LEFT_APPLIED_GAIN  = 8'h20;
    localparam logic [7:0] OFS_RIGHT_APPLIED_GAIN = 8'h21;
    localparam logic [7:0] OFS_LEFT_DEBOUNCE      = 8'h22;
    localparam logic [7:0] OFS_RIGHT_DEBOUNCE     = 8'h23;
    localparam logic [7:0] OFS_RECORD_FLAGS       = 8'h24;
    // reset values
    localparam logic [7:0] RST_APPLIED_GAIN = 8'h00;
    localparam logic [7:0] RST_DEBOUNCE     = 8'h00;
    localparam logic [6:0] RST_MAX_GAIN     = 7'h7F;
    // debounce field positions
    localparam int NOISE_DB_MSB  = 7;
    localparam int NOISE_DB_LSB  = 3;
    localparam int SIGNAL_DB_MSB = 2;
    localparam int SIGNAL_DB_LSB = 0;
    // flag bit positions
    localparam int FLAG_L_GAIN_MATCH = 7;
    localparam int FLAG_L_POWER      = 6;
    localparam int FLAG_L_QUIET      = 5;
    localparam int FLAG_L_SATURATED  = 4;
    localparam int FLAG_R_GAIN_MATCH = 3;
    localparam int FLAG_R_POWER      = 2;
    localparam int FLAG_R_QUIET      = 1;
    localparam int FLAG_R_SATURATED  = 0;
    // gain limits, half-dB codes
    localparam logic [7:0] GAIN_MIN_CODE = 8'hE8;
    localparam logic [7:0] GAIN_MAX_CODE = 8'h77;
    localparam logic [6:0] MAX_GAIN_CAP  = 7'h77;
    // timing: debounce tick of 0.5 ms, long steps of 64 ms
    localparam int CLOCK_HZ       = 25000000;
    localparam int TICK_US        = 500;
    localparam int TICK_CYCLES    = CLOCK_HZ / 1000000 * TICK_US;
    localparam int LONG_STEP_MS   = 64;
    localparam logic [4:0] LONG_CODE_BASE = 5'h07;
endpackage

// >>> rtl/agdr_regs.sv
// record-path automatic gain register bank with debounced signal detection
// Functional notes
// R1 - left applied gain readable, signed half-dB
// R2 - right applied gain readable, same encoding
// R3 - left noise debounce short codes 0-32 ms
// R4 - left noise long codes 64 ms times (code-7)
// R5 - left signal debounce 0 to 32 ms
// R6 - right noise debounce field bits 7:3
// R7 - right noise long codes step 64 ms
// R8 - right signal debounce 0 to 32 ms
// R9 - durations exact only without double-rate audio
// R10 - flag 7 left gain amplifier match
// R11 - flag 6 left converter powered
// R12 - flags 5,1 signal quiet status
// R13 - flags 4,0 gain at maximum allowed
// R14 - flag 3 right gain amplifier match
// R15 - flag 2 right converter powered
// R16 - max gain 7-bit, capped 59.5 dB
// R17 - zero noise threshold disables detection
// R18 - writes to read-only registers ignored
module agdr_regs
    import agdr_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES
)
(
    input  wire logic       CLOCK,
    input  wire logic       RESETN,
    input  wire logic       CLK_EN,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic [7:0] LEFT_GAIN_IN,
    input  wire logic [7:0] RIGHT_GAIN_IN,
    input  wire logic [6:0] LEFT_MAX_GAIN,
    input  wire logic [6:0] RIGHT_MAX_GAIN,
    input  wire logic [4:0] LEFT_NOISE_THRESH,
    input  wire logic [4:0] RIGHT_NOISE_THRESH,
    input  wire logic       LEFT_BELOW_NOISE,
    input  wire logic       RIGHT_BELOW_NOISE,
    input  wire logic       LEFT_AMP_MATCH,
    input  wire logic       RIGHT_AMP_MATCH,
    input  wire logic       LEFT_ADC_POWERED,
    input  wire logic       RIGHT_ADC_POWERED,
    input  wire logic       DOUBLE_RATE_AUDIO,
    output logic      [7:0] REG_RDATA,
    output logic            REG_RVALID,
    output logic            LEFT_QUIET,
    output logic            RIGHT_QUIET
);

    typedef enum logic [1:0]
    {
        QS_LOUD     = 2'b00,
        QS_TO_QUIET = 2'b01,
        QS_QUIET    = 2'b10,
        QS_TO_LOUD  = 2'b11
    } agdr_qstate_t;

    // duration of a debounce code in half-ms ticks
    function automatic logic [11:0] short_ticks(input logic [2:0] code);
        logic [11:0] t;
        t = 12'h000;
        if (code != 3'h0)
        begin
            t = 12'h001 << (code - 3'h1); // see R3 see R5 see R8
        end
        return t;
    endfunction

    function automatic logic [11:0] noise_ticks(input logic [4:0] code);
        logic [11:0] t;
        t = 12'h000;
        if (code > LONG_CODE_BASE)
        begin
            // 64 ms = 128 ticks per step above code 7
            t = {code - LONG_CODE_BASE, 7'h00}; // see R4 see R7
        end
        else
        begin
            t = short_ticks(code[2:0]); // see R3 see R6
        end
        return t;
    endfunction

    // saturation: applied gain equal to the capped maximum allowed gain
    function automatic logic at_max(input logic [7:0] gain, input logic [6:0] maxg);
        logic [6:0] cap;
        cap = (maxg > MAX_GAIN_CAP) ? MAX_GAIN_CAP : maxg; // see R16
        return gain == {1'b0, cap};
    endfunction

    logic [1:0]   rst_sync_r;
    logic         rst_n;
    logic [7:0]   left_gain_r;
    logic [7:0]   right_gain_r;
    logic [7:0]   left_db_r;
    logic [7:0]   right_db_r;
    logic [7:0]   flags_r;
    logic [15:0]  tick_cnt_r;
    logic         tick;
    logic [11:0]  l_cnt_r;
    logic [11:0]  r_cnt_r;
    agdr_qstate_t l_st_r;
    agdr_qstate_t r_st_r;

    // reset release through two flops
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            rst_sync_r <= 2'b00;
        end
        else
        begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // half-ms tick; in double-rate mode it runs twice as fast, so durations differ
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_cnt_r <= 16'h0000;
        end
        else if (CLK_EN)
        begin
            if (tick)
            begin
                tick_cnt_r <= 16'h0000;
            end
            else
            begin
                tick_cnt_r <= tick_cnt_r + (DOUBLE_RATE_AUDIO ? 16'h0002 : 16'h0001); // see R9
            end
        end
    end
    assign tick = tick_cnt_r >= (DOUBLE_RATE_AUDIO ? 16'(TICK_CYC - 2) : 16'(TICK_CYC - 1)); // see R9

    // applied gain capture, read-only to software
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            left_gain_r  <= RST_APPLIED_GAIN;
            right_gain_r <= RST_APPLIED_GAIN;
        end
        else if (CLK_EN)
        begin
            left_gain_r  <= LEFT_GAIN_IN;  // see R1
            right_gain_r <= RIGHT_GAIN_IN; // see R2
        end
    end

    // debounce registers; only these two accept writes
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            left_db_r  <= RST_DEBOUNCE;
            right_db_r <= RST_DEBOUNCE;
        end
        else if (CLK_EN && REG_WR)
        begin
            if (REG_ADDR == OFS_LEFT_DEBOUNCE)
            begin
                left_db_r <= REG_WDATA; // see R3 see R5
            end
            else if (REG_ADDR == OFS_RIGHT_DEBOUNCE)
            begin
                right_db_r <= REG_WDATA; // see R6 see R8
            end
        end
    end

    // left detection debounce: noise time to enter quiet, signal time to leave
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            l_st_r  <= QS_LOUD;
            l_cnt_r <= 12'h000;
        end
        else if (CLK_EN)
        begin
            if (LEFT_NOISE_THRESH == 5'h00)
            begin
                l_st_r  <= QS_LOUD; // see R17
                l_cnt_r <= 12'h000;
            end
            else
            begin
                case (l_st_r)
                    QS_LOUD:
                    begin
                        l_cnt_r <= noise_ticks(left_db_r[NOISE_DB_MSB:NOISE_DB_LSB]);
                        if (LEFT_BELOW_NOISE)
                            l_st_r <= QS_TO_QUIET;
                    end
                    QS_TO_QUIET:
                    begin
                        if (!LEFT_BELOW_NOISE)
                            l_st_r <= QS_LOUD;
                        else if (l_cnt_r == 12'h000)
                            l_st_r <= QS_QUIET; // see R4
                        else if (tick)
                            l_cnt_r <= l_cnt_r - 12'h001;
                    end
                    QS_QUIET:
                    begin
                        l_cnt_r <= short_ticks(left_db_r[SIGNAL_DB_MSB:SIGNAL_DB_LSB]);
                        if (!LEFT_BELOW_NOISE)
                            l_st_r <= QS_TO_LOUD;
                    end
                    QS_TO_LOUD:
                    begin
                        if (LEFT_BELOW_NOISE)
                            l_st_r <= QS_QUIET;
                        else if (l_cnt_r == 12'h000)
                            l_st_r <= QS_LOUD; // see R5
                        else if (tick)
                            l_cnt_r <= l_cnt_r - 12'h001;
                    end
                    default:
                        l_st_r <= QS_LOUD;
                endcase
            end
        end
    end

    // right detection debounce, same scheme
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r_st_r  <= QS_LOUD;
            r_cnt_r <= 12'h000;
        end
        else if (CLK_EN)
        begin
            if (RIGHT_NOISE_THRESH == 5'h00)
            begin
                r_st_r  <= QS_LOUD; // see R17
                r_cnt_r <= 12'h000;
            end
            else
            begin
                case (r_st_r)
                    QS_LOUD:
                    begin
                        r_cnt_r <= noise_ticks(right_db_r[NOISE_DB_MSB:NOISE_DB_LSB]);
                        if (RIGHT_BELOW_NOISE)
                            r_st_r <= QS_TO_QUIET;
                    end
                    QS_TO_QUIET:
                    begin
                        if (!RIGHT_BELOW_NOISE)
                            r_st_r <= QS_LOUD;
                        else if (r_cnt_r == 12'h000)
                            r_st_r <= QS_QUIET; // see R7
                        else if (tick)
                            r_cnt_r <= r_cnt_r - 12'h001;
                    end
                    QS_QUIET:
                    begin
                        r_cnt_r <= short_ticks(right_db_r[SIGNAL_DB_MSB:SIGNAL_DB_LSB]);
                        if (!RIGHT_BELOW_NOISE)
                            r_st_r <= QS_TO_LOUD;
                    end
                    QS_TO_LOUD:
                    begin
                        if (RIGHT_BELOW_NOISE)
                            r_st_r <= QS_QUIET;
                        else if (r_cnt_r == 12'h000)
                            r_st_r <= QS_LOUD; // see R8
                        else if (tick)
                            r_cnt_r <= r_cnt_r - 12'h001;
                    end
                    default:
                        r_st_r <= QS_LOUD;
                endcase
            end
        end
    end

    // status flags, refreshed every enabled cycle
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flags_r     <= 8'h00;
            LEFT_QUIET  <= 1'b0;
            RIGHT_QUIET <= 1'b0;
        end
        else if (CLK_EN)
        begin
            flags_r[FLAG_L_GAIN_MATCH] <= LEFT_AMP_MATCH;    // see R10
            flags_r[FLAG_L_POWER]      <= LEFT_ADC_POWERED;  // see R11
            flags_r[FLAG_L_QUIET]      <= (l_st_r == QS_QUIET) || (l_st_r == QS_TO_LOUD); // see R12
            flags_r[FLAG_L_SATURATED]  <= at_max(LEFT_GAIN_IN, LEFT_MAX_GAIN);  // see R13
            flags_r[FLAG_R_GAIN_MATCH] <= RIGHT_AMP_MATCH;   // see R14
            flags_r[FLAG_R_POWER]      <= RIGHT_ADC_POWERED; // see R15
            flags_r[FLAG_R_QUIET]      <= (r_st_r == QS_QUIET) || (r_st_r == QS_TO_LOUD); // see R12
            flags_r[FLAG_R_SATURATED]  <= at_max(RIGHT_GAIN_IN, RIGHT_MAX_GAIN); // see R13
            LEFT_QUIET                 <= (l_st_r == QS_QUIET) || (l_st_r == QS_TO_LOUD);
            RIGHT_QUIET                <= (r_st_r == QS_QUIET) || (r_st_r == QS_TO_LOUD);
        end
    end

    // read port: data one cycle after the strobe; read-only offsets never written
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            REG_RDATA  <= 8'h00;
            REG_RVALID <= 1'b0;
        end
        else if (CLK_EN)
        begin
            REG_RVALID <= REG_RD;
            if (REG_RD)
            begin
                if (REG_ADDR == OFS_LEFT_APPLIED_GAIN)
                begin
                    REG_RDATA <= left_gain_r; // see R1 see R18
                end
                else if (REG_ADDR == OFS_RIGHT_APPLIED_GAIN)
                begin
                    REG_RDATA <= right_gain_r; // see R2 see R18
                end
                else if (REG_ADDR == OFS_LEFT_DEBOUNCE)
                begin
                    REG_RDATA <= left_db_r;
                end
                else if (REG_ADDR == OFS_RIGHT_DEBOUNCE)
                begin
                    REG_RDATA <= right_db_r;
                end
                else if (REG_ADDR == OFS_RECORD_FLAGS)
                begin
                    REG_RDATA <= flags_r; // see R18
                end
                else
                begin
                    REG_RDATA <= 8'h00;
                end
            end
        end
    end

endmodule

// >>> sim/agdr_regs_assertions.sv
// checker: bus timing, readback and quiet status properties of the register bank
module agdr_regs_assertions
    import agdr_pkg::*;
(
    input wire logic       CLOCK,
    input wire logic       RESETN,
    input wire logic       CLK_EN,
    input wire logic [7:0] REG_ADDR,
    input wire logic       REG_RD,
    input wire logic [7:0] LEFT_GAIN_IN,
    input wire logic [7:0] RIGHT_GAIN_IN,
    input wire logic [4:0] LEFT_NOISE_THRESH,
    input wire logic       LEFT_BELOW_NOISE,
    input wire logic       LEFT_ADC_POWERED,
    input wire logic       RIGHT_ADC_POWERED,
    input wire logic [7:0] REG_RDATA,
    input wire logic       REG_RVALID,
    input wire logic       LEFT_QUIET
);
    // one clock domain, all checks off in reset
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESETN);
    // read answered exactly one cycle after it is taken; cycles after an enable-low cycle are not checked
    property p_rvalid;
        $past(CLK_EN) |-> REG_RVALID == $past(REG_RD);
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("read answer timing wrong");
    // read data only moves with an answer
    property p_hold;
        !REG_RVALID |-> $stable(REG_RDATA);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved without a read");
    // applied gains read back as sampled
    property p_lgain;
        $past(REG_RD && CLK_EN) && $past(REG_ADDR) == OFS_LEFT_APPLIED_GAIN && $past(CLK_EN, 2) |->
            REG_RDATA == $past(LEFT_GAIN_IN, 2);
    endproperty
    a_lgain: assert property (p_lgain) else $error("left gain readback wrong");
    property p_rgain;
        $past(REG_RD && CLK_EN) && $past(REG_ADDR) == OFS_RIGHT_APPLIED_GAIN && $past(CLK_EN, 2) |->
            REG_RDATA == $past(RIGHT_GAIN_IN, 2);
    endproperty
    a_rgain: assert property (p_rgain) else $error("right gain readback wrong");
    // unmapped reads give zero
    property p_unmapped;
        $past(REG_RD && CLK_EN) && !($past(REG_ADDR) inside {[8'h20:8'h24]}) |-> REG_RDATA == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    // converter power flags follow their inputs
    property p_power;
        $past(REG_RD && CLK_EN) && $past(REG_ADDR) == OFS_RECORD_FLAGS && $past(CLK_EN, 2) |->
            REG_RDATA[FLAG_L_POWER] == $past(LEFT_ADC_POWERED, 2) &&
            REG_RDATA[FLAG_R_POWER] == $past(RIGHT_ADC_POWERED, 2);
    endproperty
    a_power: assert property (p_power) else $error("power flag wrong");
    // zero threshold keeps detection off
    property p_thr_zero;
        (LEFT_NOISE_THRESH == 5'h00 && CLK_EN) [*3] |-> !LEFT_QUIET;
    endproperty
    a_thr_zero: assert property (p_thr_zero) else $error("quiet with detection off");
    // quiet only after the signal went below noise
    property p_quiet_rise;
        $rose(LEFT_QUIET) |-> $past(LEFT_BELOW_NOISE, 2);
    endproperty
    a_quiet_rise: assert property (p_quiet_rise) else $error("quiet without below noise");
    // main scenarios reached
    c_flags: cover property (REG_RVALID && $past(REG_ADDR) == OFS_RECORD_FLAGS);
    c_quiet: cover property ($rose(LEFT_QUIET));
    c_unmapped: cover property (REG_RVALID && $past(REG_ADDR) == 8'h25);
endmodule

bind agdr_regs agdr_regs_assertions chk_u (.CLOCK(CLOCK), .RESETN(RESETN), .CLK_EN(CLK_EN),
    .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .LEFT_GAIN_IN(LEFT_GAIN_IN), .RIGHT_GAIN_IN(RIGHT_GAIN_IN),
    .LEFT_NOISE_THRESH(LEFT_NOISE_THRESH), .LEFT_BELOW_NOISE(LEFT_BELOW_NOISE),
    .LEFT_ADC_POWERED(LEFT_ADC_POWERED), .RIGHT_ADC_POWERED(RIGHT_ADC_POWERED),
    .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .LEFT_QUIET(LEFT_QUIET));

// >>> sim/tb.sv
// testbench: register access, status flags and debounce timing of the register bank
module tb
    import agdr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 4;
    logic       clock, resetn, clk_en, reg_wr, reg_rd, double_rate_audio, lbelow, rbelow;
    logic       lamp, ramp, lpwr, rpwr, reg_rvalid, lquiet, rquiet;
    logic [7:0] reg_addr, reg_wdata, lgain, rgain, reg_rdata;
    logic [6:0] lmax, rmax;
    logic [4:0] lthr, rthr;
    int         bad_count, n_tests;

    agdr_regs #(.TICK_CYC(TK)) dut_u (.CLOCK(clock), .RESETN(resetn), .CLK_EN(clk_en),
        .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata),
        .LEFT_GAIN_IN(lgain), .RIGHT_GAIN_IN(rgain), .LEFT_MAX_GAIN(lmax), .RIGHT_MAX_GAIN(rmax),
        .LEFT_NOISE_THRESH(lthr), .RIGHT_NOISE_THRESH(rthr), .LEFT_BELOW_NOISE(lbelow),
        .RIGHT_BELOW_NOISE(rbelow), .LEFT_AMP_MATCH(lamp), .RIGHT_AMP_MATCH(ramp),
        .LEFT_ADC_POWERED(lpwr), .RIGHT_ADC_POWERED(rpwr), .DOUBLE_RATE_AUDIO(double_rate_audio),
        .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid), .LEFT_QUIET(lquiet), .RIGHT_QUIET(rquiet));

    // 25 MHz clock
    always #20 clock = ~clock;

    // compare one value and count
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", name, exp, got);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask

    // one-cycle read strobe, answer seen after the taking edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(negedge clock);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        chk("rvalid", 8'h01, {7'h00, reg_rvalid});
        chk(name, exp, reg_rdata);
    endtask

    // reset values and an unmapped read
    task automatic t_reset();
        rd(OFS_LEFT_APPLIED_GAIN, 8'h00, "lgain rst");
        rd(OFS_RIGHT_APPLIED_GAIN, 8'h00, "rgain rst");
        rd(OFS_LEFT_DEBOUNCE, 8'h00, "ldeb rst");
        rd(OFS_RIGHT_DEBOUNCE, 8'h00, "rdeb rst");
        rd(OFS_RECORD_FLAGS, 8'h00, "flags rst");
        rd(8'h25, 8'h00, "unmapped");
    endtask

    // boundary gain codes, writes to read-only places ignored
    task automatic t_gain();
        logic [7:0] tl [4] = '{8'hE8, 8'h77, 8'h00, 8'hE9};
        for (int i = 0; i < 4; i++)
        begin
            lgain = tl[i];
            rgain = tl[3 - i];
            wr(OFS_LEFT_APPLIED_GAIN, 8'h5A);
            wr(OFS_RIGHT_APPLIED_GAIN, 8'h5A);
            rd(OFS_LEFT_APPLIED_GAIN, tl[i], "lgain");
            rd(OFS_RIGHT_APPLIED_GAIN, tl[3 - i], "rgain");
        end
    endtask

    // debounce registers read back, frozen without clock enable
    task automatic t_deb_rw();
        wr(OFS_LEFT_DEBOUNCE, 8'hA5);
        wr(OFS_RIGHT_DEBOUNCE, 8'h5A);
        rd(OFS_LEFT_DEBOUNCE, 8'hA5, "ldeb");
        rd(OFS_RIGHT_DEBOUNCE, 8'h5A, "rdeb");
        clk_en = 1'b0;
        wr(OFS_LEFT_DEBOUNCE, 8'h3C);
        clk_en = 1'b1;
        rd(OFS_LEFT_DEBOUNCE, 8'hA5, "ldeb frozen");
        wr(OFS_RECORD_FLAGS, 8'hFF);
        rd(OFS_RECORD_FLAGS, 8'h00, "flags wr");
    endtask

    // match, power and saturation flags
    task automatic t_flags();
        lamp = 1'b1;
        rpwr = 1'b1;
        lgain = 8'h77;
        rd(OFS_RECORD_FLAGS, 8'h94, "flags a");
        lamp = 1'b0;
        lpwr = 1'b1;
        ramp = 1'b1;
        rpwr = 1'b0;
        lmax = 7'h20;
        lgain = 8'h21;
        rmax = 7'h10;
        rgain = 8'h10;
        rd(OFS_RECORD_FLAGS, 8'h49, "flags b");
        lgain = 8'h20;
        rgain = 8'hF0;
        rd(OFS_RECORD_FLAGS, 8'h58, "flags c");
        {lpwr, ramp, lgain, rgain, lmax, rmax} = {2'b00, 16'h0000, 14'h3FFF};
    endtask

    // quiet after the noise debounce, back after the signal debounce
    task automatic t_debounce(input bit ch, input logic [4:0] code, input logic dr, input int cyc);
        double_rate_audio = dr;
        wr(ch ? OFS_RIGHT_DEBOUNCE : OFS_LEFT_DEBOUNCE, {code, 3'h1});
        {rbelow, lbelow} = ch ? 2'b10 : 2'b01;
        repeat (cyc - 8) @(negedge clock);
        chk("quiet early", 8'h00, {7'h00, ch ? rquiet : lquiet});
        for (int k = 0; k < 24 && (ch ? rquiet : lquiet) !== 1'b1; k++)
            @(negedge clock);
        chk("quiet", 8'h01, {7'h00, ch ? rquiet : lquiet});
        rd(OFS_RECORD_FLAGS, ch ? 8'h02 : 8'h20, "quiet flag");
        {rbelow, lbelow} = 2'b00;
        for (int k = 0; k < 24 && (ch ? rquiet : lquiet) !== 1'b0; k++)
            @(negedge clock);
        chk("quiet end", 8'h00, {7'h00, ch ? rquiet : lquiet});
        double_rate_audio = 1'b0;
    endtask

    // zero threshold keeps the status clear
    task automatic t_thr_zero();
        // zero debounce: a live detector would report quiet within a few cycles
        wr(OFS_LEFT_DEBOUNCE, 8'h00);
        lthr = 5'h00;
        lbelow = 1'b1;
        repeat (40) @(negedge clock);
        chk("quiet off", 8'h00, {7'h00, lquiet});
        lbelow = 1'b0;
    endtask

    // counts, verdict and end of run
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // watchdog over the expected span
    initial
    begin
        repeat (60000) @(posedge clock);
        bad_count++;
        print_verdict();
    end

    // main sequence
    initial
    begin
        {clock, resetn, clk_en, reg_wr, reg_rd, double_rate_audio, lbelow, rbelow} = 8'h00;
        {lamp, ramp, lpwr, rpwr, reg_addr, reg_wdata, lgain, rgain} = 36'h0;
        {lmax, rmax, lthr, rthr} = {14'h3FFF, 10'h000};
        bad_count = 0;
        n_tests = 0;
        repeat (8) @(negedge clock);
        resetn = 1'b1;
        clk_en = 1'b1;
        repeat (4) @(negedge clock);
        t_reset();
        t_gain();
        t_deb_rw();
        t_flags();
        {lthr, rthr} = 10'h021;
        t_debounce(1'b0, 5'h07, 1'b0, 64 * TK);
        t_debounce(1'b0, 5'h08, 1'b0, 128 * TK);
        t_debounce(1'b0, 5'h1F, 1'b0, 3072 * TK);
        t_debounce(1'b1, 5'h1E, 1'b0, 2944 * TK);
        t_debounce(1'b0, 5'h08, 1'b1, 64 * TK);
        t_thr_zero();
        print_verdict();
    end
endmodule
